// ---- otp_sec_pkg.sv ----
// Package for the OTP security block: security bit layout, OTP geometry,
// programming control codes, test port instructions, timing and carriers.
// Assumes a single 50 MHz tile clock shared by every user of the package.
package otp_sec_pkg;

	localparam int CLK_PERIOD_NS = 20;
	localparam int TRST_MIN_NS = 100;
	localparam int TRST_MIN_CYC = (TRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int OTP_SECTORS = 4;
	localparam int OTP_ROWS = 512;
	localparam int OTP_WIDTH = 32;

	localparam int SEC_JTAG_OFF = 0;
	localparam int SEC_LINK_OFF = 1;
	localparam int SEC_SECURE_BOOT = 5;
	localparam int SEC_REDUNDANT = 7;
	localparam int SEC_LOCK_LO = 8;
	localparam int SEC_MASTER_LOCK = 12;
	localparam int SEC_JTAG_OTP_OFF = 13;
	localparam int SEC_DEBUG_OFF = 14;
	localparam int SEC_USER_LO = 15;
	localparam int SEC_USER_HI = 21;
	localparam int SEC_UID_LO = 22;
	localparam int SEC_UID_HI = 31;
	localparam logic [31:0] SEC_RESET = 32'h0000_0000;

	localparam logic [23:0] PORT_ID_ADDR = 24'h10_0200;
	localparam logic [23:0] PORT_ID_DATA = 24'h20_0100;
	localparam logic [23:0] PORT_ID_CTRL = 24'h10_0300;
	localparam logic [15:0] CTRL_PROG_ROW = 16'h0001;
	localparam logic [15:0] CTRL_PROG_SEC = 16'h0002;
	localparam logic [15:0] CTRL_READ = 16'h0004;

	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_IDCODE = 4'h1;
	localparam logic [3:0] IR_USERCODE = 4'h2;
	localparam logic [3:0] IR_OTP_RD = 4'h4;
	localparam logic [3:0] IR_OTP_WR = 4'h5;
	localparam logic [3:0] IR_TILE = 4'h6;
	localparam logic [3:0] IR_BYPASS = 4'hF;

	typedef enum logic [1:0] {BOOT_LOAD, BOOT_COPY, BOOT_RUN} boot_state_t;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} tap_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
		logic [15:0] ctrl;
		logic strobe;
	} prog_req_t;

	typedef struct packed {
		logic otpRd;
		logic otpWr;
		logic tileWr;
		logic [31:0] data;
	} tap_req_t;

endpackage : otp_sec_pkg

// ---- jtag_id_tap.sv ----
// Test access port state machine with 4-bit instruction and 32-bit data path.
// Assumes tck, tms, tdi and trstN are raw pins, oversampled by the tile clock.
`timescale 1ns/1ps
`default_nettype none
module jtag_id_tap (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trstN,
	input wire logic [31:0] idWord,
	input wire logic [31:0] userWord,
	input wire logic [31:0] otpWord,
	output logic tdo,
	output logic tdoOe,
	output otp_sec_pkg::tap_req_t req
);
	import otp_sec_pkg::*;

	logic [2:0] s1Reg, s2Reg;
	logic trstS1Reg, trstS2Reg, tckPrevReg;
	logic [3:0] trstCntReg;
	tap_state_t stateReg;
	logic [3:0] irReg, irShReg;
	logic [31:0] drReg;
	logic tckRise, tckFall, tapHold;

	function automatic tap_state_t nextTap(input tap_state_t s, input logic m);
		unique case (s)
			TAP_RESET: nextTap = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: nextTap = m ? SEL_DR : TAP_IDLE;
			SEL_DR: nextTap = m ? SEL_IR : CAP_DR;
			CAP_DR, SH_DR: nextTap = m ? EX1_DR : SH_DR;
			EX1_DR, EX2_DR: nextTap = m ? UPD_DR : (s == EX1_DR ? PA_DR : SH_DR);
			PA_DR: nextTap = m ? EX2_DR : PA_DR;
			UPD_DR, UPD_IR: nextTap = m ? SEL_DR : TAP_IDLE;
			SEL_IR: nextTap = m ? TAP_RESET : CAP_IR;
			CAP_IR, SH_IR: nextTap = m ? EX1_IR : SH_IR;
			EX1_IR, EX2_IR: nextTap = m ? UPD_IR : (s == EX1_IR ? PA_IR : SH_IR);
			PA_IR: nextTap = m ? EX2_IR : PA_IR;
		endcase
	endfunction : nextTap

	// Two flops on every pin before use; only the second stage is looked at
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1Reg <= 3'h0;
			s2Reg <= 3'h0;
			trstS1Reg <= 1'b0;
			trstS2Reg <= 1'b0;
			tckPrevReg <= 1'b0;
		end else begin
			s1Reg <= {tck, tms, tdi};
			s2Reg <= s1Reg;
			trstS1Reg <= trstN;
			trstS2Reg <= trstS1Reg;
			tckPrevReg <= s2Reg[2];
		end
	end

	assign tckRise = s2Reg[2] & ~tckPrevReg;
	assign tckFall = ~s2Reg[2] & tckPrevReg;
	assign tapHold = ~trstS2Reg | (trstCntReg != 4'(TRST_MIN_CYC));

	// Test logic stays in reset until the reset pin has been high long enough
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			trstCntReg <= 4'h0;
		else if (!trstS2Reg)
			trstCntReg <= 4'h0;
		else if (tapHold)
			trstCntReg <= trstCntReg + 4'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= TAP_RESET;
			irReg <= IR_IDCODE;
			irShReg <= 4'h0;
			drReg <= 32'h0000_0000;
			req <= '0;
		end else begin
			req <= '0;
			if (tapHold || stateReg == TAP_RESET) begin
				irReg <= IR_IDCODE;
			end
			if (tapHold) begin
				stateReg <= TAP_RESET;
			end else if (tckRise) begin
				stateReg <= nextTap(stateReg, s2Reg[1]);
				unique case (stateReg)
					CAP_IR: irShReg <= IR_CAPTURE;
					SH_IR: irShReg <= {s2Reg[0], irShReg[3:1]};
					UPD_IR: irReg <= irShReg;
					CAP_DR: begin
						unique case (irReg)
							IR_IDCODE: drReg <= idWord;
							IR_USERCODE: drReg <= userWord;
							IR_OTP_RD: drReg <= otpWord;
							default: drReg <= 32'h0000_0000;
						endcase
					end
					SH_DR: begin
						if (irReg == IR_BYPASS)
							drReg <= {31'h0000_0000, s2Reg[0]};
						else
							drReg <= {s2Reg[0], drReg[31:1]};
					end
					UPD_DR: begin
						req.otpRd <= irReg == IR_OTP_RD;
						req.otpWr <= irReg == IR_OTP_WR;
						req.tileWr <= irReg == IR_TILE;
						req.data <= drReg;
					end
					default: ;
				endcase
			end
		end
	end

	// Data leaves on the falling test clock so the host samples it stable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo <= 1'b0;
			tdoOe <= 1'b0;
		end else if (tckFall) begin
			tdo <= (stateReg == SH_IR) ? irShReg[0] : drReg[0];
			tdoOe <= (stateReg == SH_IR) || (stateReg == SH_DR);
		end
	end

	default clocking cbTap @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_id_capture;
		(!tapHold && tckRise && stateReg == CAP_DR && irReg == IR_IDCODE)
			|=> drReg[0] && drReg == $past(idWord);
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("id word not captured");

endmodule : jtag_id_tap
`default_nettype wire

// ---- otp_security_jtag_id.sv ----
// OTP store, power-up security load, boot copy, programming and test port gating.
// Assumes one tile clock, rst_n as power-up reset and raw pins for the test port.
//
// Functional notes
// - OTP is four sectors of 512 rows, each row a 32-bit word.
// - Security word loads from OTP before the tile starts running.
// - Bit 0 blocks test-port access to tile state and memory.
// - Bit 1 refuses switch access from other tiles to this processor.
// - Bit 5 skips boot ROM and boots from OTP word 0.
// - Bit 7 enables redundant OTP rows.
// - Bits 8 to 11 each lock programming of sectors 0 to 3.
// - Bit 12 rejects all programming, sectors and security word alike.
// - Bit 13 denies test-port reads and writes of the OTP.
// - Bit 14 disables the debug pin in both directions.
// - Bits 15 to 21 are user bits; 22 to 31 extend the user id.
// - After load, remaining OTP is copied into SRAM and run first.
// - Test port has a 4-bit instruction and 32-bit data register.
// - Output mode: debug pin floats until a breakpoint, then drives low.
// - Input mode: debug pin pulled low puts the tile in debug.
// - Identification word carries version, part, maker and bit 0 one.
// - User code word takes its id from security bits 22 to 31.
// - Secure boot clear means booting from internal flash.
`timescale 1ns/1ps
`default_nettype none
module otp_security_jtag_id #(
	parameter int SECTORS = otp_sec_pkg::OTP_SECTORS,
	parameter int ROWS = otp_sec_pkg::OTP_ROWS,
	parameter logic [3:0] ID_VERSION = 4'h0, // Arbitrary value
	parameter logic [15:0] ID_PART = 16'h0A5C, // Arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h123, // Arbitrary value
	parameter logic [15:0] SILICON_REV = 16'h0001 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire otp_sec_pkg::prog_req_t prog,
	output logic progDone,
	output logic progRejected,
	output logic [31:0] progRdData,
	output logic sramWe,
	output logic [$clog2(SECTORS*ROWS)-1:0] sramAddr,
	output logic [31:0] sramData,
	output logic cpuRun,
	output logic bootFromOtp,
	output logic bootFromFlash,
	output logic redundantEn,
	output logic [6:0] userBits,
	input wire logic linkReq,
	output logic linkGrant,
	output logic linkRefused,
	output logic tileAccStrobe,
	output logic [31:0] tileAccData,
	output logic tapDenied,
	input wire logic breakpointHit,
	input wire logic bpClear,
	input wire logic dbgOutMode,
	input wire logic dbgInMode,
	input wire logic debugIn,
	output logic debugOut,
	output logic debugOe,
	output logic debugEnter,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trstN,
	output logic tdo,
	output logic tdoOe
);
	import otp_sec_pkg::*;

	localparam int DEPTH = SECTORS * ROWS;
	localparam int AW = $clog2(DEPTH);
	localparam int RW = $clog2(ROWS);
	localparam logic [AW-1:0] LAST_ROW = AW'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Storage and live security copy

	// Fuses blow one way only, so a row can gain ones but never lose them
	logic [OTP_WIDTH-1:0] otpMem [DEPTH] = '{default: '0};
	logic [OTP_WIDTH-1:0] otpSec = '0;
	logic [31:0] secLive;
	boot_state_t stateReg, stateNext;
	logic [AW-1:0] copyIdx;
	logic [15:0] tapAddrReg;
	logic [31:0] tapOtpWord;
	tap_req_t tapReq;
	logic bpStickyReg, dbgS1Reg, dbgS2Reg, dbgPrevReg;

	function automatic logic lockedF(input logic [31:0] sec, input logic [15:0] addr);
		logic [15:0] sector;
		sector = addr >> RW;
		lockedF = sec[SEC_MASTER_LOCK] || (addr >= 16'(DEPTH)) ||
			sec[SEC_LOCK_LO + int'(sector)];
	endfunction : lockedF

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic isRun, isCopy, lastCopy;
	logic progRow, progSecCmd, progRead, rowLock, rowWrOk, secWrOk;
	logic tapBlock, tapWrOk, tapWrLock;
	logic [AW-1:0] progIdx, tapIdx;
	logic dbgFall, dbgOff;
	logic [31:0] idWord, userWord;

	assign isRun = stateReg == BOOT_RUN;
	assign isCopy = stateReg == BOOT_COPY;
	assign lastCopy = isCopy && copyIdx == LAST_ROW;
	assign progRow = isRun && prog.strobe && prog.ctrl == CTRL_PROG_ROW;
	assign progSecCmd = isRun && prog.strobe && prog.ctrl == CTRL_PROG_SEC;
	assign progRead = isRun && prog.strobe && prog.ctrl == CTRL_READ;
	assign progIdx = prog.addr[AW-1:0];
	assign rowLock = lockedF(secLive, prog.addr);
	assign rowWrOk = progRow && !rowLock;
	assign secWrOk = progSecCmd && !secLive[SEC_MASTER_LOCK];
	assign tapBlock = secLive[SEC_JTAG_OFF] || secLive[SEC_JTAG_OTP_OFF];
	assign tapIdx = tapAddrReg[AW-1:0];
	assign tapWrLock = lockedF(secLive, tapAddrReg);
	// The software port wins a clash; the test port write is then refused
	assign tapWrOk = isRun && tapReq.otpWr && !tapBlock && !tapWrLock && !progRow;
	assign dbgFall = dbgPrevReg && !dbgS2Reg;
	assign dbgOff = secLive[SEC_DEBUG_OFF];
	assign idWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	assign userWord = {secLive[SEC_UID_HI:SEC_UID_LO], 6'h00, SILICON_REV};

	always_ff @(posedge clk) begin
		if (rowWrOk)
			otpMem[progIdx] <= otpMem[progIdx] | prog.data;
		else if (tapWrOk)
			otpMem[tapIdx] <= otpMem[tapIdx] | tapReq.data;
		if (secWrOk)
			otpSec <= otpSec | prog.data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sequence: load security word, copy OTP to SRAM, then run

	always_comb begin
		stateNext = stateReg;
		unique case (stateReg)
			BOOT_LOAD: stateNext = BOOT_COPY;
			BOOT_COPY: stateNext = lastCopy ? BOOT_RUN : BOOT_COPY;
			BOOT_RUN: stateNext = BOOT_RUN;
		endcase
	end

	// The live copy only changes at load, so new fuses wait for a power-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= BOOT_LOAD;
			secLive <= SEC_RESET;
		end else begin
			stateReg <= stateNext;
			if (stateReg == BOOT_LOAD)
				secLive <= otpSec;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			copyIdx <= '0;
			sramWe <= 1'b0;
			sramAddr <= '0;
			sramData <= 32'h0000_0000;
		end else begin
			sramWe <= isCopy;
			sramAddr <= copyIdx;
			sramData <= otpMem[copyIdx];
			if (isCopy)
				copyIdx <= copyIdx + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuRun <= 1'b0;
			bootFromOtp <= 1'b0;
			bootFromFlash <= 1'b0;
			redundantEn <= 1'b0;
			userBits <= 7'h00;
		end else begin
			cpuRun <= isRun;
			bootFromOtp <= isRun && secLive[SEC_SECURE_BOOT];
			bootFromFlash <= isRun && !secLive[SEC_SECURE_BOOT];
			redundantEn <= secLive[SEC_REDUNDANT];
			userBits <= secLive[SEC_USER_HI:SEC_USER_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software programming port results

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			progDone <= 1'b0;
			progRejected <= 1'b0;
			progRdData <= 32'h0000_0000;
		end else begin
			progDone <= rowWrOk || secWrOk || progRead;
			progRejected <= (progRow && rowLock) || (progSecCmd && !secWrOk) ||
				(prog.strobe && !isRun);
			if (progRead)
				progRdData <= otpMem[progIdx];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test port access to OTP and tile, switch access

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tapAddrReg <= 16'h0000;
			tapOtpWord <= 32'h0000_0000;
			tapDenied <= 1'b0;
		end else begin
			tapDenied <= ((tapReq.otpRd || tapReq.otpWr) && (tapBlock || !isRun)) ||
				(tapReq.otpWr && (tapWrLock || progRow)) ||
				(tapReq.tileWr && secLive[SEC_JTAG_OFF]);
			if (tapReq.otpRd) begin
				tapAddrReg <= tapReq.data[15:0];
				tapOtpWord <= (tapBlock || !isRun) ? 32'h0000_0000 :
					otpMem[tapReq.data[AW-1:0]];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tileAccStrobe <= 1'b0;
			tileAccData <= 32'h0000_0000;
			linkGrant <= 1'b0;
			linkRefused <= 1'b0;
		end else begin
			tileAccStrobe <= isRun && tapReq.tileWr && !secLive[SEC_JTAG_OFF];
			if (tapReq.tileWr && !secLive[SEC_JTAG_OFF])
				tileAccData <= tapReq.data;
			linkGrant <= isRun && linkReq && !secLive[SEC_LINK_OFF];
			linkRefused <= linkReq && (!isRun || secLive[SEC_LINK_OFF]);
		end
	end

	jtag_id_tap u_tap (
		.clk(clk),
		.rst_n(rst_n),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.trstN(trstN),
		.idWord(idWord),
		.userWord(userWord),
		.otpWord(tapOtpWord),
		.tdo(tdo),
		.tdoOe(tdoOe),
		.req(tapReq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Debug synchronisation pin

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dbgS1Reg <= 1'b1;
			dbgS2Reg <= 1'b1;
			dbgPrevReg <= 1'b1;
			bpStickyReg <= 1'b0;
		end else begin
			dbgS1Reg <= debugIn;
			dbgS2Reg <= dbgS1Reg;
			dbgPrevReg <= dbgS2Reg;
			// A breakpoint in the clear cycle still holds the pin
			if (breakpointHit)
				bpStickyReg <= 1'b1;
			else if (bpClear)
				bpStickyReg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debugOut <= 1'b0;
			debugOe <= 1'b0;
			debugEnter <= 1'b0;
		end else begin
			debugOut <= 1'b0;
			debugOe <= dbgOutMode && bpStickyReg && !dbgOff;
			debugEnter <= isRun && dbgInMode && dbgFall && !dbgOff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cbMain @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_run_after_copy;
		$rose(cpuRun) |-> $past(sramWe) && $past(sramAddr) == LAST_ROW;
	endproperty
	a_run_after_copy: assert property (p_run_after_copy) else $error("run before copy end");

	property p_sec_frozen;
		isRun && $past(isRun) |-> $stable(secLive);
	endproperty
	a_sec_frozen: assert property (p_sec_frozen) else $error("live security changed");

	property p_tile_block;
		tileAccStrobe |-> !secLive[SEC_JTAG_OFF];
	endproperty
	a_tile_block: assert property (p_tile_block) else $error("tile access while blocked");

	property p_link_block;
		linkGrant |-> !$past(secLive[SEC_LINK_OFF]) && !linkRefused;
	endproperty
	a_link_block: assert property (p_link_block) else $error("link granted while off");

	property p_boot_src;
		cpuRun |-> bootFromOtp == secLive[SEC_SECURE_BOOT] && bootFromFlash != bootFromOtp;
	endproperty
	a_boot_src: assert property (p_boot_src) else $error("wrong boot source");

	property p_redundant;
		cpuRun |-> redundantEn == secLive[SEC_REDUNDANT];
	endproperty
	a_redundant: assert property (p_redundant) else $error("redundant enable wrong");

	property p_row_lock;
		progRow && rowLock |=> progRejected && !progDone &&
			otpMem[$past(progIdx)] == $past(otpMem[progIdx]);
	endproperty
	a_row_lock: assert property (p_row_lock) else $error("locked row programmed");

	property p_master_lock;
		progSecCmd && secLive[SEC_MASTER_LOCK] |=> progRejected && $stable(otpSec);
	endproperty
	a_master_lock: assert property (p_master_lock) else $error("master lock ignored");

	property p_tap_otp;
		tapReq.otpRd && secLive[SEC_JTAG_OTP_OFF] |=> tapDenied && tapOtpWord == 32'h0000_0000;
	endproperty
	a_tap_otp: assert property (p_tap_otp) else $error("test port read not denied");

	property p_dbg_off;
		secLive[SEC_DEBUG_OFF] && isRun |=> !debugOe && !debugEnter;
	endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("debug pin active while off");

	property p_dbg_in;
		isRun && dbgInMode && !dbgOff && dbgFall |=> debugEnter;
	endproperty
	a_dbg_in: assert property (p_dbg_in) else $error("debug entry missed");

	c_run: cover property ($rose(cpuRun));
	c_reject: cover property (progRejected);
	c_tap_denied: cover property (tapDenied);
	c_dbg_enter: cover property (debugEnter);

endmodule : otp_security_jtag_id
`default_nettype wire

// ---- jtag_host_model.sv ----
// Test port host model: drives test clock, mode select, data in and test reset.
// Assumes the tile clock paces it; each test clock phase lasts five tile cycles.
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
	input wire logic clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trstN
);
	// Test clock stands low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trstN = 1'b0;
	end
	////////////////////////////////////////
	task automatic trst(input logic v);
		trstN = v;
	endtask : trst
	// Five cycles a phase keeps clear of the pin synchroniser latency
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		repeat (5) @(posedge clk);
		#1 o = tdo;
		tck = 1'b1;
		repeat (5) @(posedge clk);
		#1 tck = 1'b0;
	endtask : step
	task automatic reset_tap();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask : reset_tap
	// From idle, shifts n bits least significant first and returns to idle
	task automatic shift(input logic isIr, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (isIr) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask : shift
endmodule : jtag_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Testbench for the OTP security block: boots three times with growing fuse words.
// Assumes a shrunken OTP of 16 rows and the host model on the test port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import otp_sec_pkg::*;
	localparam int NR = 16;
	localparam logic [31:0] ID_EXP = {4'h0, 16'h0A5C, 11'h123, 1'b1};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic booted = 1'b0;
	prog_req_t prog = '0;
	logic progDone, progRejected, sramWe, cpuRun, bootFromOtp, bootFromFlash, redundantEn;
	logic [31:0] progRdData, sramData, tileAccData, lastTile;
	logic [3:0] sramAddr;
	logic [6:0] userBits;
	logic linkReq = 1'b0, linkGrant, linkRefused, tileAccStrobe, tapDenied;
	logic breakpointHit = 1'b0, bpClear = 1'b0, dbgOutMode = 1'b0, dbgInMode = 1'b0;
	logic dbgLow = 1'b0, debugIn, debugOut, debugOe, debugEnter;
	logic tck, tms, tdi, trstN, tdo, tdoOe, tdoPin;
	logic [31:0] otpModel [NR];
	logic [31:0] sramSeen [NR];
	logic [31:0] secFuse = '0, secLive = '0;
	logic [34:0] notes [$];
	logic [34:0] note;
	int num_errors = 0, samples_checked = 0, weCnt = 0, denyCnt = 0, tileCnt = 0, dbgCnt = 0;
	always #10 clk = ~clk;
	// Debug pin has a pull-up; released test data out shows the inverse
	assign debugIn = !(debugOe || dbgLow);
	assign tdoPin = tdoOe ? tdo : ~tdo;
	otp_security_jtag_id #(.SECTORS(4), .ROWS(4)) otp_security_jtag_id_i (
		.clk(clk), .rst_n(rst_n), .prog(prog), .progDone(progDone),
		.progRejected(progRejected), .progRdData(progRdData), .sramWe(sramWe),
		.sramAddr(sramAddr), .sramData(sramData), .cpuRun(cpuRun), .bootFromOtp(bootFromOtp),
		.bootFromFlash(bootFromFlash), .redundantEn(redundantEn), .userBits(userBits),
		.linkReq(linkReq), .linkGrant(linkGrant), .linkRefused(linkRefused),
		.tileAccStrobe(tileAccStrobe), .tileAccData(tileAccData), .tapDenied(tapDenied),
		.breakpointHit(breakpointHit), .bpClear(bpClear), .dbgOutMode(dbgOutMode),
		.dbgInMode(dbgInMode), .debugIn(debugIn), .debugOut(debugOut), .debugOe(debugOe),
		.debugEnter(debugEnter), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo),
		.tdoOe(tdoOe));
	jtag_host_model jtag_host_model_i (.clk(clk), .tdo(tdoPin), .tck(tck), .tms(tms),
		.tdi(tdi), .trstN(trstN));
	////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// Result watcher: every answer pulse consumes the oldest note
	always @(posedge clk) begin
		#1;
		if (progDone === 1'b1 || progRejected === 1'b1) begin
			note = notes.size() ? notes.pop_front() : '1;
			check({progDone, progRejected, note[34] ? progRdData : 32'h0}, note[33:0]);
		end
		if (sramWe === 1'b1) begin
			sramSeen[sramAddr] = sramData;
			weCnt++;
		end
		if (tapDenied === 1'b1) denyCnt++;
		if (tileAccStrobe === 1'b1) begin
			tileCnt++;
			lastTile = tileAccData;
		end
		if (debugEnter === 1'b1) dbgCnt++;
	end
	////////////////////////////////////////
	task automatic cmd(input logic [15:0] a, input logic [31:0] d, input logic [15:0] c);
		logic rej, rd;
		rej = !booted || (c == CTRL_PROG_SEC && secLive[12]) || (c == CTRL_PROG_ROW &&
			(secLive[12] || a >= NR || secLive[8 + a / 4]));
		rd = !rej && c == CTRL_READ;
		if (!rej && c == CTRL_PROG_ROW) otpModel[a] = otpModel[a] | d;
		if (!rej && c == CTRL_PROG_SEC) secFuse = secFuse | d;
		@(posedge clk);
		#1 prog = '{a, d, c, 1'b1};
		if (c inside {CTRL_PROG_ROW, CTRL_PROG_SEC, CTRL_READ})
			notes.push_back({rd, !rej, rej, rd ? otpModel[a[3:0]] : 32'h0});
	endtask : cmd
	task automatic idle();
		@(posedge clk);
		#1 prog.strobe = 1'b0;
	endtask : idle
	task automatic outs();
		check({bootFromOtp, bootFromFlash, redundantEn, userBits},
			{secLive[5], !secLive[5], secLive[7], secLive[21:15]});
	endtask : outs
	task automatic boot();
		int k;
		rst_n = 1'b0;
		booted = 1'b0;
		secLive = secFuse;
		jtag_host_model_i.trst(1'b0);
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		weCnt = 0;
		cmd(16'h0000, 32'h0, CTRL_READ);
		idle();
		k = 0;
		while (cpuRun !== 1'b1 && k < 200) begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 200) begin
			check(1'b0, 1'b1);
			wrap_up();
		end
		#1 booted = 1'b1;
		jtag_host_model_i.trst(1'b1);
		check(weCnt, NR);
		for (int i = 0; i < NR; i++) check(sramSeen[i], otpModel[i]);
		outs();
	endtask : boot
	task automatic jtag_ir(input logic [3:0] code);
		logic [31:0] c;
		jtag_host_model_i.shift(1'b1, {28'h0, code}, 4, c);
		check(c[3:0], 4'h1);
	endtask : jtag_ir
	task automatic pulse_wait(ref logic s);
		s = 1'b1;
		@(posedge clk);
		#1 s = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse_wait
	// Same probe each boot; expectations follow the live fuse word
	task automatic probe();
		logic [31:0] r, w;
		int d0;
		logic wrBlk;
		w = $urandom;
		linkReq = 1'b1;
		repeat (2) @(posedge clk);
		#1 check({linkGrant, linkRefused}, secLive[1] ? 2'b01 : 2'b10);
		linkReq = 1'b0;
		jtag_host_model_i.reset_tap();
		jtag_host_model_i.shift(1'b0, 32'h0, 32, r);
		check(r, ID_EXP);
		jtag_ir(IR_USERCODE);
		jtag_host_model_i.shift(1'b0, 32'h0, 32, r);
		check(r, {secLive[31:22], 6'h00, 16'h0001});
		d0 = denyCnt;
		jtag_ir(IR_OTP_RD);
		jtag_host_model_i.shift(1'b0, 32'h5, 32, r);
		jtag_host_model_i.shift(1'b0, 32'h5, 32, r);
		check(r, (secLive[0] || secLive[13]) ? 32'h0 : otpModel[5]);
		check(denyCnt != d0, secLive[0] || secLive[13]);
		// Test port write lands on the address of the last test port read
		wrBlk = secLive[0] || secLive[13] || secLive[12] || secLive[9];
		d0 = denyCnt;
		jtag_ir(IR_OTP_WR);
		jtag_host_model_i.shift(1'b0, w, 32, r);
		if (!wrBlk) otpModel[5] = otpModel[5] | w;
		check(denyCnt != d0, wrBlk);
		d0 = tileCnt;
		jtag_ir(IR_TILE);
		jtag_host_model_i.shift(1'b0, w, 32, r);
		check({tileCnt != d0, lastTile}, secLive[0] ? {1'b0, lastTile} : {1'b1, w});
		dbgOutMode = 1'b1;
		check(debugOe, 1'b0);
		pulse_wait(breakpointHit);
		check({debugOe, debugOut}, {!secLive[14], 1'b0});
		pulse_wait(bpClear);
		check(debugOe, 1'b0);
		dbgOutMode = 1'b0;
		d0 = dbgCnt;
		dbgInMode = 1'b1;
		pulse_wait(dbgLow);
		repeat (3) @(posedge clk);
		#1 check(dbgCnt != d0, !secLive[14]);
		dbgInMode = 1'b0;
		cmd(16'h0001, w, CTRL_PROG_ROW);
		cmd(16'h0005, w ^ 32'h0F0F_0F0F, CTRL_PROG_ROW);
		cmd(16'h0005, 32'h8000_0001, CTRL_PROG_ROW);
		cmd(16'h0010, w, CTRL_PROG_ROW);
		cmd(16'h0000, 32'h0, CTRL_PROG_SEC);
		cmd(16'h0001, 32'h0, 16'h0008);
		idle();
		cmd(16'h0001, 32'h0, CTRL_READ);
		cmd(16'h0005, 32'h0, CTRL_READ);
		idle();
		repeat (2) @(posedge clk);
	endtask : probe
	////////////////////////////////////////
	initial begin
		void'($urandom(87));
		for (int i = 0; i < NR; i++) otpModel[i] = '0;
		boot();
		probe();
		// Disables test port, link and debug pin, locks sector 1, boots from OTP
		cmd(16'h0000, ($urandom & 32'hFFFF_8000) | 32'h0000_62A3, CTRL_PROG_SEC);
		idle();
		repeat (2) @(posedge clk);
		outs();
		boot();
		probe();
		cmd(16'h0000, 32'h0000_1000, CTRL_PROG_SEC);
		idle();
		boot();
		probe();
		check(notes.size(), 0);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
